// ===== core/ocs_regs.svh
// Register map, field positions and reset values of the oscillator block.
// Assumes a 16-bit register file behind an 8-bit AXI4-Lite byte address.
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH
// -----------------------------------------------------------------------
// Offsets
// -----------------------------------------------------------------------
`define OCS_ADDR_SLOW 8'h00
`define OCS_ADDR_FAST 8'h04
`define OCS_ADDR_FLAGS 8'h08
`define OCS_ADDR_IRQEN 8'h0c
`define OCS_ADDR_SRC 8'h10
`define OCS_ADDR_TRIM 8'h14
// -----------------------------------------------------------------------
// Slow oscillator control fields
// -----------------------------------------------------------------------
`define OCS_SLOW_WT 0
`define OCS_SLOW_NGAIN 4
`define OCS_SLOW_BGAIN 6
`define OCS_SLOW_CAP 8
`define OCS_SLOW_TYPE 11
`define OCS_SLOW_BOOST 12
`define OCS_SLOW_STOPDET 13
`define OCS_SLOW_RESTART 14
`define OCS_SLOW_RESET 16'h5092
`define OCS_SLOW_MASK 16'h7ff3
// -----------------------------------------------------------------------
// Fast oscillator control fields
// -----------------------------------------------------------------------
`define OCS_FAST_WT 0
`define OCS_FAST_GAIN 4
`define OCS_FAST_MD 8
`define OCS_FAST_FQ 10
`define OCS_FAST_RESET 16'h0c16
`define OCS_FAST_MASK 16'h1f37
`define OCS_FAST_LAST_SHIFT 3'h5
// -----------------------------------------------------------------------
// Flags, enables, source control and trimming
// -----------------------------------------------------------------------
`define OCS_FLG_INT 0
`define OCS_FLG_SLOW 1
`define OCS_FLG_FAST 2
`define OCS_FLG_TRIM 4
`define OCS_FLG_STOP 5
`define OCS_FLG_MASK 16'h0037
`define OCS_SRC_RESET 4'h1
`define OCS_SRC_MASK 16'h000f
`define OCS_FAST_WAIT_0 4
`define OCS_TRIM_BIT 4
`define OCS_SLOW_WAIT_1 4096
`define OCS_RESP_OKAY 2'h0
`define OCS_RESP_SLVERR 2'h2
`endif

// ===== core/ocs_pkg.sv
// Types shared by the oscillator configuration and status block.
// Assumes the analog oscillator cells consume the configuration struct.
package ocs_pkg;
	typedef enum logic [1:0] {
		FAST_INTERNAL = 2'h0,
		FAST_CR = 2'h1,
		FAST_XTAL = 2'h2
	} ocs_fast_mode_type;
	typedef struct packed {
		logic int_en;
		logic slow_en;
		logic fast_en;
		logic ext_en;
		logic slow_type_int;
		logic [2:0] slow_gate_cap;
		logic slow_boost_active;
		logic [1:0] slow_gain;
		logic slow_restart_en;
		logic stop_det_en;
		logic [2:0] fast_freq;
		logic [1:0] fast_type;
		logic [1:0] fast_gain;
		logic trim_run;
	} ocs_cfg_type;
endpackage

// ===== core/ocs_core.sv
// Oscillator configuration, stabilization wait counters and event flags.
// Assumes oscillator clocks and analog events arrive asynchronously on pins.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`include "ocs_regs.svh"
module ocs_core #(
	parameter int CNT_W = 17,
	parameter int SLOW_WAIT_2 = 16384,
	parameter int SLOW_WAIT_3 = 65536,
	parameter int FAST_WAIT_6 = 16384,
	parameter int FAST_WAIT_7 = 65536,
	parameter int INT_WAIT = 256
) (
	// Clock, reset and enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Oscillator pins: internal, slow, fast
	input wire logic [2:0] osc_clk_in,
	input wire logic stop_detect_in,
	input wire logic trim_done_in,
	// Configuration and interrupt
	output ocs_pkg::ocs_cfg_type osc_cfg,
	output logic irq
);
	// -------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------
	// A pin edge counts only once the second and third stages agree, so a
	// metastable first stage never produces a spurious count.
	localparam int NPIN = 5;
	logic [NPIN-1:0] pin_in;
	logic [NPIN-1:0] rise;
	assign pin_in = {trim_done_in, stop_detect_in, osc_clk_in};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			logic s1_q, s2_q, s3_q, lvl_q;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
				end else if (ce) begin
					s1_q <= pin_in[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign rise[gi] = s2_q & s3_q & ~lvl_q;
		end
	endgenerate
	// -------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------
	logic [15:0] slow_q, fast_q, flags_q, irqen_q;
	logic [3:0] src_q;
	logic trim_run_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_full_q, w_full_q;
	logic do_wr;
	logic [15:0] wmask;
	logic [15:0] flags_d;
	logic [2:0] stab_evt;
	logic trim_evt, stop_evt, trim_wr;
	assign do_wr = ce & aw_full_q & w_full_q & ~bvalid;
	assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign trim_wr = do_wr && waddr_q == `OCS_ADDR_TRIM && wstrb_q[0];
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] keep);
		merge = (old & ~(wmask & keep)) | (wdata_q[15:0] & wmask & keep);
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_q <= `OCS_SLOW_RESET;
			fast_q <= `OCS_FAST_RESET;
			irqen_q <= 16'h0000;
			src_q <= `OCS_SRC_RESET;
		end else if (do_wr) begin
			unique case (waddr_q)
				`OCS_ADDR_SLOW: slow_q <= merge(slow_q, `OCS_SLOW_MASK);
				`OCS_ADDR_FAST: fast_q <= merge(fast_q, `OCS_FAST_MASK);
				`OCS_ADDR_IRQEN: irqen_q <= merge(irqen_q, `OCS_FLG_MASK);
				`OCS_ADDR_SRC: src_q <=
					4'(merge({12'h000, src_q}, `OCS_SRC_MASK));
				default: ;
			endcase
		end
	end
	// Completion of trimming clears the start bit unless software writes
	// the bit in the same cycle, in which case the write is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trim_run_q <= 1'b0;
		end else if (ce) begin
			if (trim_wr) begin
				trim_run_q <= wdata_q[`OCS_TRIM_BIT];
			end else if (trim_evt) begin
				trim_run_q <= 1'b0;
			end
		end
	end
	// -------------------------------------------------------------------
	// Stabilization counters
	// -------------------------------------------------------------------
	logic [2:0] src_en;
	logic [CNT_W-1:0] wait_len [3];
	logic [CNT_W-1:0] cnt_q [3];
	logic [2:0] done_q;
	assign src_en = src_q[2:0];
	always_comb begin
		unique case (slow_q[`OCS_SLOW_WT +: 2])
			2'h2: wait_len[1] = CNT_W'(SLOW_WAIT_2);
			2'h3: wait_len[1] = CNT_W'(SLOW_WAIT_3);
			default: wait_len[1] = CNT_W'(`OCS_SLOW_WAIT_1);
		endcase
		if (fast_q[`OCS_FAST_WT +: 3] <= `OCS_FAST_LAST_SHIFT) begin
			wait_len[2] = CNT_W'(1) <<
				(2 * fast_q[`OCS_FAST_WT +: 3] + 2);
		end else if (fast_q[`OCS_FAST_WT]) begin
			wait_len[2] = CNT_W'(FAST_WAIT_7);
		end else begin
			wait_len[2] = CNT_W'(FAST_WAIT_6);
		end
		wait_len[0] = CNT_W'(INT_WAIT);
	end
	// The internal oscillator is already running out of reset, so its
	// counter starts done and raises no event.
	generate
		for (gi = 0; gi < 3; gi++) begin : g_stab
			assign stab_evt[gi] = ce & src_en[gi] & ~done_q[gi] & rise[gi]
				& (CNT_W'(cnt_q[gi] + 1'b1) >= wait_len[gi]);
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cnt_q[gi] <= '0;
					done_q[gi] <= (gi == 0);
				end else if (ce) begin
					if (!src_en[gi]) begin
						cnt_q[gi] <= '0;
						done_q[gi] <= 1'b0;
					end else if (stab_evt[gi]) begin
						done_q[gi] <= 1'b1;
					end else if (!done_q[gi] && rise[gi]) begin
						cnt_q[gi] <= CNT_W'(cnt_q[gi] + 1'b1);
					end
				end
			end
		end
	endgenerate
	// -------------------------------------------------------------------
	// Event flags and interrupt
	// -------------------------------------------------------------------
	assign trim_evt = ce & trim_run_q & rise[4];
	assign stop_evt = ce & slow_q[`OCS_SLOW_STOPDET] & rise[3];
	always_comb begin
		flags_d = flags_q;
		if (do_wr && waddr_q == `OCS_ADDR_FLAGS) begin
			flags_d = flags_q & ~(wdata_q[15:0] & wmask);
		end
		flags_d[`OCS_FLG_INT] = flags_d[`OCS_FLG_INT] | stab_evt[0];
		flags_d[`OCS_FLG_SLOW] = flags_d[`OCS_FLG_SLOW] | stab_evt[1];
		flags_d[`OCS_FLG_FAST] = flags_d[`OCS_FLG_FAST] | stab_evt[2];
		flags_d[`OCS_FLG_TRIM] = flags_d[`OCS_FLG_TRIM] | trim_evt;
		flags_d[`OCS_FLG_STOP] = flags_d[`OCS_FLG_STOP] | stop_evt;
		flags_d = flags_d & `OCS_FLG_MASK;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= 16'h0000;
			irq <= 1'b0;
		end else if (ce) begin
			flags_q <= flags_d;
			irq <= |(flags_q & irqen_q);
		end
	end
	// -------------------------------------------------------------------
	// Oscillator configuration
	// -------------------------------------------------------------------
	ocs_pkg::ocs_cfg_type cfg_d;
	always_comb begin
		cfg_d = '0;
		cfg_d.int_en = src_q[0];
		cfg_d.slow_en = src_q[1];
		cfg_d.fast_en = src_q[2];
		cfg_d.ext_en = src_q[3];
		cfg_d.slow_type_int = slow_q[`OCS_SLOW_TYPE];
		cfg_d.slow_gate_cap = slow_q[`OCS_SLOW_CAP +: 3];
		cfg_d.slow_boost_active = slow_q[`OCS_SLOW_BOOST] & src_q[1]
			& ~done_q[1] & ~slow_q[`OCS_SLOW_TYPE];
		cfg_d.slow_gain = cfg_d.slow_boost_active ?
			slow_q[`OCS_SLOW_BGAIN +: 2] :
			slow_q[`OCS_SLOW_NGAIN +: 2];
		cfg_d.slow_restart_en = slow_q[`OCS_SLOW_RESTART];
		cfg_d.stop_det_en = slow_q[`OCS_SLOW_STOPDET];
		cfg_d.fast_freq = fast_q[`OCS_FAST_FQ +: 3];
		cfg_d.fast_type = fast_q[`OCS_FAST_MD +: 2];
		if (fast_q[`OCS_FAST_MD +: 2] == ocs_pkg::FAST_XTAL) begin
			cfg_d.fast_gain = fast_q[`OCS_FAST_GAIN +: 2];
		end
		cfg_d.trim_run = trim_run_q;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_cfg <= '0;
		end else if (ce) begin
			osc_cfg <= cfg_d;
		end
	end
	// -------------------------------------------------------------------
	// AXI4-Lite slave
	// -------------------------------------------------------------------
	// Address and data are latched independently so either may come first.
	assign awready = ce & ~aw_full_q & ~bvalid;
	assign wready = ce & ~w_full_q & ~bvalid;
	assign arready = ce & ~rvalid;
	function automatic logic mapped(input logic [7:0] a);
		mapped = a == `OCS_ADDR_SLOW || a == `OCS_ADDR_FAST ||
			a == `OCS_ADDR_FLAGS || a == `OCS_ADDR_IRQEN ||
			a == `OCS_ADDR_SRC || a == `OCS_ADDR_TRIM;
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `OCS_RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_full_q <= 1'b1;
				waddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_full_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= mapped(waddr_q) ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `OCS_RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= mapped(araddr) ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
				unique case (araddr)
					`OCS_ADDR_SLOW: rdata <= {16'h0000, slow_q};
					`OCS_ADDR_FAST: rdata <= {16'h0000, fast_q};
					`OCS_ADDR_FLAGS: rdata <= {16'h0000, flags_q};
					`OCS_ADDR_IRQEN: rdata <= {16'h0000, irqen_q};
					`OCS_ADDR_SRC: rdata <= {28'h0000000, src_q};
					`OCS_ADDR_TRIM: rdata <= 32'(trim_run_q) << `OCS_TRIM_BIT;
					default: rdata <= 32'h0000_0000;
				endcase
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_slow_clear;
		do_wr && waddr_q == `OCS_ADDR_FLAGS && wstrb_q[0] &&
			wdata_q[`OCS_FLG_SLOW] && !stab_evt[1];
	endsequence
	sequence s_trim_end;
		trim_evt && !trim_wr;
	endsequence
	AST_SLOW_TYPE: assert property (ce |=>
		osc_cfg.slow_type_int == $past(slow_q[`OCS_SLOW_TYPE]))
		else $error("Slow type output does not follow its bit.");
	AST_SLOW_WAIT: assert property (stab_evt[1] &&
		slow_q[`OCS_SLOW_WT +: 2] == 2'h1 |->
		cnt_q[1] == CNT_W'(`OCS_SLOW_WAIT_1 - 1))
		else $error("Slow wait of code one is not 4096 clocks.");
	AST_FAST_WAIT: assert property (stab_evt[2] &&
		fast_q[`OCS_FAST_WT +: 3] == 3'h0 |->
		cnt_q[2] == CNT_W'(`OCS_FAST_WAIT_0 - 1))
		else $error("Fast wait of code zero is not 4 clocks.");
	AST_FAST_GAIN: assert property (ce &&
		fast_q[`OCS_FAST_MD +: 2] != ocs_pkg::FAST_XTAL |=>
		osc_cfg.fast_gain == 2'h0)
		else $error("Fast gain applied outside crystal mode.");
	AST_SLOW_SET: assert property (stab_evt[1] |=>
		flags_q[`OCS_FLG_SLOW])
		else $error("Slow stable flag not set after its wait.");
	AST_SLOW_CLEAR: assert property (s_slow_clear |=>
		!flags_q[`OCS_FLG_SLOW])
		else $error("Writing one did not clear the slow flag.");
	AST_INT_RESET: assert property (!$past(aresetn) |->
		!flags_q[`OCS_FLG_INT] && !stab_evt[0])
		else $error("Internal stable flag set after reset.");
	AST_IRQ: assert property (ce |=>
		irq == |($past(flags_q) & $past(irqen_q)))
		else $error("Interrupt does not follow flags and enables.");
	AST_IRQ_MASK: assert property (ce && irqen_q == 16'h0000 |=>
		!irq)
		else $error("Interrupt raised with all enables clear.");
	AST_TRIM_END: assert property (s_trim_end |=>
		!trim_run_q && flags_q[`OCS_FLG_TRIM])
		else $error("Trim start bit not cleared on completion.");
	AST_STOP_GATE: assert property (ce &&
		!slow_q[`OCS_SLOW_STOPDET] && !flags_q[`OCS_FLG_STOP] &&
		!(do_wr && waddr_q == `OCS_ADDR_SLOW) |=> !flags_q[`OCS_FLG_STOP])
		else $error("Stop flag set with detector off.");
	AST_BOOST: assert property (ce && !slow_q[`OCS_SLOW_BOOST] |=>
		!osc_cfg.slow_boost_active)
		else $error("Boost active with boost disabled.");
	AST_SRC_EN: assert property (ce |=>
		osc_cfg.fast_en == $past(src_q[2]))
		else $error("Fast enable output does not follow its bit.");
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the oscillator configuration and status block.
// Assumes the block answers on AXI4-Lite and counts slow pin edges.
`include "ocs_regs.svh"
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("MISMATCH %s exp %h got %h", nm, e, g); \
	end \
end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic [2:0] osc_clk_in = 3'h0;
	logic stop_detect_in = 1'b0;
	logic trim_done_in = 1'b0;
	ocs_pkg::ocs_cfg_type osc_cfg;
	logic irq;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [1:0] rr;
	always #50 aclk = ~aclk;
	// Long waits are shortened so the slow count finishes in a few hundred
	// cycles; the expected counts below follow these values.
	ocs_core #(.SLOW_WAIT_2(20), .SLOW_WAIT_3(30), .FAST_WAIT_6(20),
		.FAST_WAIT_7(30), .INT_WAIT(4)) u_dut (.aclk(aclk),
		.aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.osc_clk_in(osc_clk_in), .stop_detect_in(stop_detect_in),
		.trim_done_in(trim_done_in), .osc_cfg(osc_cfg), .irq(irq));
	// -------------------------------------------------------------------
	// Bus tasks
	// -------------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ha;
		logic hw;
		logic hb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end while (!hb);
		bready <= 1'b0;
		`CHK("bresp", er, r)
		@(posedge aclk);
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic h;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			h = arvalid && arready;
			@(posedge aclk);
		end while (!h);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			h = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end while (!h);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		rdr(a, rd, rr);
		`CHK("rdata", {16'h0000, e}, rd)
		`CHK("rresp", `OCS_RESP_OKAY, rr)
	endtask
	// Each level is held four cycles so the pin synchronizers see it.
	task automatic pump(input int idx, input int n);
		repeat (n) begin
			osc_clk_in <= osc_clk_in | 3'(1 << idx);
			repeat (4) @(posedge aclk);
			osc_clk_in <= osc_clk_in & ~3'(1 << idx);
			repeat (4) @(posedge aclk);
		end
		repeat (8) @(posedge aclk);
	endtask
	task automatic pulse_stop();
		stop_detect_in <= 1'b1;
		repeat (4) @(posedge aclk);
		stop_detect_in <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	task automatic done(input string t);
		$display("test %s done", t);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// -------------------------------------------------------------------
	// Watchdog
	// -------------------------------------------------------------------
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	// -------------------------------------------------------------------
	// Tests
	// -------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk(`OCS_ADDR_SLOW, `OCS_SLOW_RESET);
		rchk(`OCS_ADDR_FAST, `OCS_FAST_RESET);
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		rchk(`OCS_ADDR_IRQEN, 16'h0000);
		rchk(`OCS_ADDR_SRC, 16'h0001);
		`CHK("int_en", 1'b1, osc_cfg.int_en)
		rdr(8'h18, rd, rr);
		`CHK("unmapped_resp", `OCS_RESP_SLVERR, rr)
		wr(8'h18, 32'h0000_ffff, `OCS_RESP_SLVERR);
		done("reset");
		wr(`OCS_ADDR_SLOW, 32'h0000_0f00, `OCS_RESP_OKAY);
		rchk(`OCS_ADDR_SLOW, 16'h0f00);
		`CHK("slow_type", 1'b1, osc_cfg.slow_type_int)
		`CHK("gate_cap", 3'h7, osc_cfg.slow_gate_cap)
		done("slow_fields");
		for (int k = 0; k < 6; k++) begin
			wr(`OCS_ADDR_FAST, 32'h0230 | (k << 10), `OCS_RESP_OKAY);
			`CHK("fast_freq", k[2:0], osc_cfg.fast_freq)
			`CHK("fast_type", 2'h2, osc_cfg.fast_type)
			`CHK("fast_gain", 2'h3, osc_cfg.fast_gain)
		end
		wr(`OCS_ADDR_FAST, 32'h0000_0130, `OCS_RESP_OKAY);
		`CHK("fast_type_cr", 2'h1, osc_cfg.fast_type)
		`CHK("fast_gain_cr", 2'h0, osc_cfg.fast_gain)
		done("fast_fields");
		wr(`OCS_ADDR_FAST, 32'h0000_0000, `OCS_RESP_OKAY);
		wr(`OCS_ADDR_SRC, 32'h0000_0005, `OCS_RESP_OKAY);
		`CHK("fast_en", 1'b1, osc_cfg.fast_en)
		pump(2, 3);
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		pump(2, 1);
		rchk(`OCS_ADDR_FLAGS, 16'h0004);
		wr(`OCS_ADDR_IRQEN, 32'h0000_0004, `OCS_RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK("irq_on", 1'b1, irq)
		wr(`OCS_ADDR_FLAGS, 32'h0000_0000, `OCS_RESP_OKAY);
		rchk(`OCS_ADDR_FLAGS, 16'h0004);
		wr(`OCS_ADDR_FLAGS, 32'h0000_0004, `OCS_RESP_OKAY);
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		`CHK("irq_off", 1'b0, irq)
		done("fast_wait");
		wr(`OCS_ADDR_SLOW, 32'h0000_10d2, `OCS_RESP_OKAY);
		wr(`OCS_ADDR_SRC, 32'h0000_0003, `OCS_RESP_OKAY);
		`CHK("boost_on", 1'b1, osc_cfg.slow_boost_active)
		`CHK("boost_gain", 2'h3, osc_cfg.slow_gain)
		pump(1, 19);
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		pump(1, 1);
		rchk(`OCS_ADDR_FLAGS, 16'h0002);
		`CHK("boost_off", 1'b0, osc_cfg.slow_boost_active)
		`CHK("normal_gain", 2'h1, osc_cfg.slow_gain)
		wr(`OCS_ADDR_FLAGS, 32'h0000_0037, `OCS_RESP_OKAY);
		done("slow_wait");
		pulse_stop();
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		wr(`OCS_ADDR_SLOW, 32'h0000_30d2, `OCS_RESP_OKAY);
		`CHK("stop_det", 1'b1, osc_cfg.stop_det_en)
		pulse_stop();
		rchk(`OCS_ADDR_FLAGS, 16'h0020);
		wr(`OCS_ADDR_FLAGS, 32'h0000_0020, `OCS_RESP_OKAY);
		// A stop pulse seen only while the clock enable is low must be lost.
		ce <= 1'b0;
		pulse_stop();
		ce <= 1'b1;
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		done("stop");
		wr(`OCS_ADDR_TRIM, 32'h0000_0010, `OCS_RESP_OKAY);
		rchk(`OCS_ADDR_TRIM, 16'h0010);
		`CHK("trim_run", 1'b1, osc_cfg.trim_run)
		trim_done_in <= 1'b1;
		repeat (8) @(posedge aclk);
		trim_done_in <= 1'b0;
		rchk(`OCS_ADDR_TRIM, 16'h0000);
		rchk(`OCS_ADDR_FLAGS, 16'h0010);
		wr(`OCS_ADDR_FLAGS, 32'h0000_0010, `OCS_RESP_OKAY);
		done("trim");
		wr(`OCS_ADDR_SRC, 32'h0000_000c, `OCS_RESP_OKAY);
		`CHK("ext_en", 1'b1, osc_cfg.ext_en)
		wr(`OCS_ADDR_SRC, 32'h0000_0005, `OCS_RESP_OKAY);
		pump(0, 4);
		rchk(`OCS_ADDR_FLAGS, 16'h0001);
		wr(`OCS_ADDR_IRQEN, 32'h0000_0001, `OCS_RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK("irq_int", 1'b1, irq)
		done("internal");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK("irq_reset", 1'b0, irq)
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		rchk(`OCS_ADDR_IRQEN, 16'h0000);
		pump(0, 4);
		rchk(`OCS_ADDR_FLAGS, 16'h0000);
		done("second_reset");
		close_out();
	end
endmodule
